// ===== src/nfm_flash_master.sv
// Behaviour
// - state readable, init right after boot
// - detection ends detached or slow link
// - no flash: pins fixed, data-in hi-z
// - full-speed command checks blob, enters full
// - detach accepted anywhere, stops all traffic
// - detached: manual deselect, send, receive
// - reconnect from detached restores communication
// - bitmap fetch allowed only in full
// - full speed uses four data lines
// - engine reads assets without host relay
`timescale 1ns/100ps
module nfm_flash_master #(
   parameter logic [31:0] BLOB_SIG = 32'h5A5A_A5A5  // arbitrary signature value
) (
   input  wire logic        REF_CLK_I,
   input  wire logic        RST_I,
   input  wire logic        CMD_GO_FULL_SPEED_I,
   input  wire logic        CMD_DISCONNECT_NOR_I,
   input  wire logic        CMD_RECONNECT_NOR_I,
   input  wire logic        CMD_MANUAL_DESELECT_I,
   input  wire logic        CMD_MANUAL_SEND_I,
   input  wire logic [7:0]  MAN_TX_BYTE_I,
   input  wire logic        CMD_MANUAL_RECEIVE_I,
   input  wire logic        CMD_FLUSH_BITMAP_CACHE_I,
   output logic      [1:0]  FLASH_STATE_O,
   output logic             CMD_DONE_O,
   output logic      [7:0]  MAN_RX_BYTE_O,
   output logic             MAN_RX_VALID_O,
   output logic             CACHE_FLUSH_O,
   input  wire logic        RD_REQ_I,
   input  wire logic [23:0] RD_ADDR_I,
   output logic             RD_READY_O,
   output logic      [7:0]  RD_DATA_O,
   output logic             RD_VALID_O,
   output logic             NOR_SCLK_O,
   output logic             NOR_CS_N_O,
   output logic      [3:0]  NOR_IO_O,
   output logic      [3:0]  NOR_IO_OE_O,
   input  wire logic [3:0]  NOR_IO_I
);

   nfm_pkg::nfm_seq_e   seq_ff;
   nfm_pkg::nfm_flash_e fstate_ff;
   logic [3:0]  io_meta_ff;
   logic [3:0]  io_sync_ff;
   logic        nor_data_in_line;
   logic        ld_ff;
   logic [5:0]  ld_units_ff;
   logic        ld_quad_ff;
   logic        ld_rx_ff;
   logic [31:0] ld_data_ff;
   logic        busy_ff;
   logic        done_ff;
   logic        sclk_ff;
   logic [3:0]  half_ff;
   logic [3:0]  half_lim;
   logic [5:0]  units_ff;
   logic        quad_ff;
   logic        rx_ff;
   logic [31:0] sh_ff;
   logic        cs_low_ff;
   logic [23:0] rd_addr_ff;
   logic        abort;

   assign abort = CMD_DISCONNECT_NOR_I;
   assign nor_data_in_line = io_sync_ff[1];

   // pins come from the flash's timing, not ours
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         io_meta_ff <= 4'h0;
         io_sync_ff <= 4'h0;
      end else begin
         io_meta_ff <= NOR_IO_I;
         io_sync_ff <= io_meta_ff;
      end
   end

   // bit engine: data changes on falling sclk, flash samples on rising
   assign half_lim = (fstate_ff == nfm_pkg::FL_FULL) ? nfm_pkg::FULL_HALF - 4'h1
                                                     : nfm_pkg::SLOW_HALF - 4'h1;

   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         busy_ff  <= 1'b0;
         done_ff  <= 1'b0;
         sclk_ff  <= 1'b0;
         half_ff  <= 4'h0;
         units_ff <= 6'h00;
         quad_ff  <= 1'b0;
         rx_ff    <= 1'b0;
         sh_ff    <= 32'h0000_0000;
      end else begin
         done_ff <= 1'b0;
         if (abort) begin
            busy_ff <= 1'b0;
            sclk_ff <= 1'b0;
            quad_ff <= 1'b0;
            rx_ff   <= 1'b0;
         end else if (ld_ff) begin
            busy_ff  <= 1'b1;
            sclk_ff  <= 1'b0;
            half_ff  <= 4'h0;
            units_ff <= ld_units_ff;
            quad_ff  <= ld_quad_ff;
            rx_ff    <= ld_rx_ff;
            sh_ff    <= ld_data_ff;
         end else if (busy_ff) begin
            if (half_ff == half_lim) begin
               half_ff <= 4'h0;
               sclk_ff <= ~sclk_ff;
               if (sclk_ff) begin
                  // synced input still shows this unit: two-clock sync delay is below one unit
                  if (rx_ff && quad_ff) begin
                     sh_ff <= {sh_ff[27:0], io_sync_ff};
                  end else if (rx_ff) begin
                     sh_ff <= {sh_ff[30:0], nor_data_in_line};
                  end else if (quad_ff) begin
                     sh_ff <= {sh_ff[27:0], 4'h0};
                  end else begin
                     sh_ff <= {sh_ff[30:0], 1'b0};
                  end
                  units_ff <= units_ff - 6'h01;
                  if (units_ff == 6'h01) begin
                     busy_ff <= 1'b0;
                     done_ff <= 1'b1;
                     quad_ff <= 1'b0;
                     rx_ff   <= 1'b0;
                  end
               end
            end else begin
               half_ff <= half_ff + 4'h1;
            end
         end
      end
   end

   // sequencer
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         seq_ff      <= nfm_pkg::SQ_BOOT;
         fstate_ff   <= nfm_pkg::FL_INIT;
         ld_ff       <= 1'b0;
         ld_units_ff <= 6'h00;
         ld_quad_ff  <= 1'b0;
         ld_rx_ff    <= 1'b0;
         ld_data_ff  <= 32'h0000_0000;
         cs_low_ff   <= 1'b0;
         rd_addr_ff  <= 24'h000000;
      end else begin
         ld_ff      <= 1'b0;
         ld_quad_ff <= 1'b0;
         ld_rx_ff   <= 1'b0;
         if (abort) begin
            seq_ff    <= nfm_pkg::SQ_DETACHED;
            fstate_ff <= nfm_pkg::FL_DETACHED;
            cs_low_ff <= 1'b0;
         end else begin
            unique case (seq_ff)
               nfm_pkg::SQ_BOOT: begin
                  cs_low_ff   <= 1'b1;
                  ld_ff       <= 1'b1;
                  ld_units_ff <= nfm_pkg::UNITS_BYTE;
                  ld_data_ff  <= {nfm_pkg::OP_READ_ID, 24'h000000};
                  seq_ff      <= nfm_pkg::SQ_DET_CMD;
               end
               nfm_pkg::SQ_DET_CMD: if (done_ff) begin
                  ld_ff       <= 1'b1;
                  ld_rx_ff    <= 1'b1;
                  ld_units_ff <= nfm_pkg::UNITS_ID;
                  seq_ff      <= nfm_pkg::SQ_DET_RX;
               end
               nfm_pkg::SQ_DET_RX: if (done_ff) begin
                  cs_low_ff <= 1'b0;
                  if (sh_ff[23:0] == nfm_pkg::ID_NONE_HI ||
                      sh_ff[23:0] == nfm_pkg::ID_NONE_LO) begin
                     seq_ff    <= nfm_pkg::SQ_DETACHED;
                     fstate_ff <= nfm_pkg::FL_DETACHED;
                  end else begin
                     seq_ff    <= nfm_pkg::SQ_SLOW;
                     fstate_ff <= nfm_pkg::FL_SLOW;
                  end
               end
               nfm_pkg::SQ_DETACHED: begin
                  if (CMD_RECONNECT_NOR_I) begin
                     seq_ff    <= nfm_pkg::SQ_BOOT;
                     cs_low_ff <= 1'b0;
                  end else if (CMD_MANUAL_DESELECT_I) begin
                     cs_low_ff <= 1'b0;
                  end else if (CMD_MANUAL_SEND_I) begin
                     cs_low_ff   <= 1'b1;
                     ld_ff       <= 1'b1;
                     ld_units_ff <= nfm_pkg::UNITS_BYTE;
                     ld_data_ff  <= {MAN_TX_BYTE_I, 24'h000000};
                     seq_ff      <= nfm_pkg::SQ_MAN_TX;
                  end else if (CMD_MANUAL_RECEIVE_I) begin
                     cs_low_ff   <= 1'b1;
                     ld_ff       <= 1'b1;
                     ld_rx_ff    <= 1'b1;
                     ld_units_ff <= nfm_pkg::UNITS_BYTE;
                     seq_ff      <= nfm_pkg::SQ_MAN_RX;
                  end
               end
               nfm_pkg::SQ_MAN_TX,
               nfm_pkg::SQ_MAN_RX: if (done_ff) begin
                  seq_ff <= nfm_pkg::SQ_DETACHED;  // chip select stays low for chaining
               end
               nfm_pkg::SQ_SLOW: if (CMD_GO_FULL_SPEED_I) begin
                  cs_low_ff   <= 1'b1;
                  ld_ff       <= 1'b1;
                  ld_units_ff <= nfm_pkg::UNITS_WORD;
                  ld_data_ff  <= {nfm_pkg::OP_READ_SLOW, nfm_pkg::BLOB_ADDR};
                  seq_ff      <= nfm_pkg::SQ_CHK_CMD;
               end
               nfm_pkg::SQ_CHK_CMD: if (done_ff) begin
                  ld_ff       <= 1'b1;
                  ld_rx_ff    <= 1'b1;
                  ld_units_ff <= nfm_pkg::UNITS_WORD;
                  seq_ff      <= nfm_pkg::SQ_CHK_RX;
               end
               nfm_pkg::SQ_CHK_RX: if (done_ff) begin
                  cs_low_ff <= 1'b0;
                  // without a programmed blob the link stays slow
                  if (sh_ff == BLOB_SIG) begin
                     seq_ff    <= nfm_pkg::SQ_FULL;
                     fstate_ff <= nfm_pkg::FL_FULL;
                  end else begin
                     seq_ff <= nfm_pkg::SQ_SLOW;
                  end
               end
               nfm_pkg::SQ_FULL: if (RD_REQ_I) begin
                  cs_low_ff   <= 1'b1;
                  rd_addr_ff  <= RD_ADDR_I;
                  ld_ff       <= 1'b1;
                  ld_units_ff <= nfm_pkg::UNITS_BYTE;
                  ld_data_ff  <= {nfm_pkg::OP_READ_QUAD, 24'h000000};
                  seq_ff      <= nfm_pkg::SQ_RD_CMD;
               end
               nfm_pkg::SQ_RD_CMD: if (done_ff) begin
                  ld_ff       <= 1'b1;
                  ld_quad_ff  <= 1'b1;
                  ld_units_ff <= nfm_pkg::UNITS_QADR;
                  ld_data_ff  <= {rd_addr_ff, nfm_pkg::XIP_MODE_BYTE};
                  seq_ff      <= nfm_pkg::SQ_RD_ADR;
               end
               nfm_pkg::SQ_RD_ADR: if (done_ff) begin
                  ld_ff       <= 1'b1;
                  ld_quad_ff  <= 1'b1;
                  ld_rx_ff    <= 1'b1;
                  ld_units_ff <= nfm_pkg::UNITS_QDUMMY;
                  seq_ff      <= nfm_pkg::SQ_RD_DUM;
               end
               nfm_pkg::SQ_RD_DUM: if (done_ff) begin
                  ld_ff       <= 1'b1;
                  ld_quad_ff  <= 1'b1;
                  ld_rx_ff    <= 1'b1;
                  ld_units_ff <= nfm_pkg::UNITS_QBYTE;
                  seq_ff      <= nfm_pkg::SQ_RD_DAT;
               end
               nfm_pkg::SQ_RD_DAT: if (done_ff) begin
                  cs_low_ff <= 1'b0;
                  seq_ff    <= nfm_pkg::SQ_FULL;
               end
               default: begin
                  seq_ff    <= nfm_pkg::SQ_DETACHED;
                  fstate_ff <= nfm_pkg::FL_DETACHED;
                  cs_low_ff <= 1'b0;
               end
            endcase
         end
      end
   end

   // answers to the command side
   always_ff @(posedge REF_CLK_I) begin
      if (RST_I) begin
         CMD_DONE_O     <= 1'b0;
         MAN_RX_BYTE_O  <= 8'h00;
         MAN_RX_VALID_O <= 1'b0;
         RD_DATA_O      <= 8'h00;
         RD_VALID_O     <= 1'b0;
         CACHE_FLUSH_O  <= 1'b0;
      end else begin
         CACHE_FLUSH_O  <= CMD_FLUSH_BITMAP_CACHE_I;
         MAN_RX_VALID_O <= 1'b0;
         RD_VALID_O     <= 1'b0;
         CMD_DONE_O     <= abort;
         if (!abort && done_ff) begin
            if (seq_ff == nfm_pkg::SQ_MAN_RX) begin
               MAN_RX_BYTE_O  <= sh_ff[7:0];
               MAN_RX_VALID_O <= 1'b1;
            end
            if (seq_ff == nfm_pkg::SQ_RD_DAT) begin
               RD_DATA_O  <= sh_ff[7:0];
               RD_VALID_O <= 1'b1;
            end
            if (seq_ff == nfm_pkg::SQ_MAN_RX || seq_ff == nfm_pkg::SQ_MAN_TX ||
                seq_ff == nfm_pkg::SQ_DET_RX || seq_ff == nfm_pkg::SQ_CHK_RX) begin
               CMD_DONE_O <= 1'b1;
            end
         end
      end
   end

   assign FLASH_STATE_O = fstate_ff;
   assign RD_READY_O    = (seq_ff == nfm_pkg::SQ_FULL) && !abort;
   assign NOR_SCLK_O    = sclk_ff;
   assign NOR_CS_N_O    = ~cs_low_ff;

   // single mode keeps write-protect and hold high; data-in line never driven
   always_comb begin
      if (quad_ff && rx_ff) begin
         NOR_IO_O    = 4'h0;
         NOR_IO_OE_O = 4'h0;
      end else if (quad_ff) begin
         NOR_IO_O    = sh_ff[31:28];
         NOR_IO_OE_O = 4'hF;
      end else begin
         NOR_IO_O    = {2'b11, 1'b0, sh_ff[31] & busy_ff & ~rx_ff};
         NOR_IO_OE_O = 4'hD;
      end
   end

endmodule

// ===== src/nfm_pkg.sv
package nfm_pkg;

   // reported flash subsystem state, one fixed code each
   typedef enum logic [1:0] {
      FL_INIT     = 2'h0,
      FL_DETACHED = 2'h1,
      FL_SLOW     = 2'h2,
      FL_FULL     = 2'h3
   } nfm_flash_e;

   typedef enum logic [3:0] {
      SQ_BOOT     = 4'h0,
      SQ_DET_CMD  = 4'h1,
      SQ_DET_RX   = 4'h2,
      SQ_DETACHED = 4'h3,
      SQ_SLOW     = 4'h4,
      SQ_FULL     = 4'h5,
      SQ_CHK_CMD  = 4'h6,
      SQ_CHK_RX   = 4'h7,
      SQ_RD_CMD   = 4'h8,
      SQ_RD_ADR   = 4'h9,
      SQ_RD_DUM   = 4'hA,
      SQ_RD_DAT   = 4'hB,
      SQ_MAN_TX   = 4'hC,
      SQ_MAN_RX   = 4'hD
   } nfm_seq_e;

   localparam logic [7:0]  OP_READ_ID    = 8'h9F;
   localparam logic [7:0]  OP_READ_SLOW  = 8'h03;
   localparam logic [7:0]  OP_READ_QUAD  = 8'hEB;
   localparam logic [7:0]  XIP_MODE_BYTE = 8'hA0;
   localparam logic [23:0] ID_NONE_HI    = 24'hFFFFFF;
   localparam logic [23:0] ID_NONE_LO    = 24'h000000;
   localparam logic [23:0] BLOB_ADDR     = 24'h000000;
   localparam int          BLOB_BYTES    = 4096;
   localparam logic [5:0]  UNITS_BYTE    = 6'h08;
   localparam logic [5:0]  UNITS_ID      = 6'h18;
   localparam logic [5:0]  UNITS_WORD    = 6'h20;
   localparam logic [5:0]  UNITS_QADR    = 6'h08;
   localparam logic [5:0]  UNITS_QDUMMY  = 6'h04;
   localparam logic [5:0]  UNITS_QBYTE   = 6'h02;
   localparam int          SYS_CLK_MHZ   = 125;
   localparam int          PEAK_MBIT_S   = 288;
   // half sclk periods in system clocks
   localparam logic [3:0]  SLOW_HALF     = 4'h4;
   localparam logic [3:0]  FULL_HALF     = 4'h2;

endpackage

// ===== testbench/nfm_flash_model.sv
`timescale 1ns/100ps
module nfm_flash_model #(
   parameter logic [23:0] ID = 24'h5C3A17  // arbitrary id value
) (
   input  wire logic        sclk_i,
   input  wire logic        cs_n_i,
   input  wire logic [3:0]  io_i,
   input  wire logic        present_i,
   input  wire logic [31:0] blob_i,
   output logic      [3:0]  io_o
);
   logic [3:0]  drv_q = 4'hF;
   logic [7:0]  cnt;
   logic [7:0]  adr;
   logic [31:0] inr;
   logic [31:0] sh;
   logic        drv;
   logic        quad;
   logic        rd;
   // missing part reads as pulled-up lines
   assign io_o = present_i ? drv_q : 4'hF;
   always @(negedge cs_n_i) begin
      cnt = 8'h00;
      drv = 1'b0;
      quad = 1'b0;
      rd = 1'b0;
   end
   // released lines show the inverse so a stale sample cannot pass
   always @(posedge cs_n_i) drv_q = ~drv_q;
   always @(posedge sclk_i) begin
      if (!cs_n_i) begin
         inr = quad ? {inr[27:0], io_i} : {inr[30:0], io_i[0]};
         cnt = cnt + 8'h01;
         if (cnt == 8'h08) begin
            quad = inr[7:0] == 8'hEB;
            rd = inr[7:0] == 8'h03;
            drv = inr[7:0] == 8'h9F;
            sh = {ID, 8'h00};
         end
         if (quad && cnt == 8'h0E) adr = inr[7:0];
         if (quad && cnt == 8'h14) begin
            drv = 1'b1;
            sh = {4{adr ^ 8'h5A}};
         end
         if (rd && cnt == 8'h20) begin
            drv = 1'b1;
            sh = blob_i;
         end
      end
   end
   always @(negedge sclk_i) begin
      if (!cs_n_i && drv) begin
         if (quad) drv_q = sh[31:28];
         else drv_q[1] = sh[31];
         sh = quad ? sh << 4 : sh << 1;
      end
   end
endmodule

// ===== testbench/nfm_flash_master_checker.sv
`timescale 1ns/100ps
module nfm_flash_master_checker (
   input  wire logic       REF_CLK_I,
   input  wire logic       RST_I,
   input  wire logic       CMD_DISCONNECT_NOR_I,
   input  wire logic       CMD_MANUAL_SEND_I,
   input  wire logic       CMD_FLUSH_BITMAP_CACHE_I,
   input  wire logic       RD_REQ_I,
   input  wire logic [1:0] FLASH_STATE_O,
   input  wire logic       CMD_DONE_O,
   input  wire logic       CACHE_FLUSH_O,
   input  wire logic       RD_READY_O,
   input  wire logic       RD_VALID_O,
   input  wire logic       NOR_SCLK_O,
   input  wire logic       NOR_CS_N_O,
   input  wire logic [3:0] NOR_IO_O,
   input  wire logic [3:0] NOR_IO_OE_O
);
   default clocking cb @(posedge REF_CLK_I); endclocking
   default disable iff (RST_I);
   AST_BOOT_INIT: assert property (disable iff (1'b0)
      RST_I |=> FLASH_STATE_O == 2'h0 && NOR_CS_N_O) else $error("not init after reset");
   AST_DETACH_NOW: assert property (
      CMD_DISCONNECT_NOR_I |=> FLASH_STATE_O == 2'h1 && CMD_DONE_O ##[0:2] NOR_CS_N_O)
      else $error("detach not taken");
   AST_DETACH_QUIET: assert property (
      CMD_DISCONNECT_NOR_I |-> !RD_READY_O ##1 !RD_VALID_O [*8]) else $error("read after detach");
   AST_READY_ONLY_FULL: assert property (
      RD_READY_O |-> FLASH_STATE_O == 2'h3) else $error("read ready outside full");
   AST_VALID_ONLY_FULL: assert property (
      RD_VALID_O |-> FLASH_STATE_O == 2'h3) else $error("read data outside full");
   AST_STATE_STEPS: assert property (
      $changed(FLASH_STATE_O) |-> FLASH_STATE_O == 2'h1 || $past(FLASH_STATE_O) == 2'h1
      || {$past(FLASH_STATE_O), FLASH_STATE_O} inside {4'h2, 4'hB}) else $error("bad state step");
   AST_DATA_IN_HIZ: assert property (
      FLASH_STATE_O != 2'h3 && $past(FLASH_STATE_O) != 2'h3 |-> !NOR_IO_OE_O[1])
      else $error("data-in line driven");
   AST_DETACHED_PINS_FIXED: assert property (
      FLASH_STATE_O == 2'h1 && NOR_CS_N_O ##1 NOR_CS_N_O
      |-> $stable(NOR_IO_O) && $stable(NOR_IO_OE_O) && !NOR_SCLK_O) else $error("idle pins move");
   AST_FULL_SCLK: assert property (
      FLASH_STATE_O == 2'h3 && $rose(NOR_SCLK_O) && !CMD_DISCONNECT_NOR_I
      |=> NOR_SCLK_O ##1 !NOR_SCLK_O) else $error("full speed clock wrong");
   AST_READ_QUAD: assert property (
      RD_REQ_I && RD_READY_O |-> ##[1:48] NOR_IO_OE_O == 4'hF) else $error("no quad phase");
   AST_MANUAL_SEND: assert property (
      FLASH_STATE_O == 2'h1 && CMD_MANUAL_SEND_I |-> ##[60:80] CMD_DONE_O)
      else $error("manual send not done");
   AST_FLUSH_ECHO: assert property (
      CMD_FLUSH_BITMAP_CACHE_I |=> CACHE_FLUSH_O) else $error("flush not echoed");
endmodule
bind nfm_flash_master nfm_flash_master_checker i_chk (.REF_CLK_I, .RST_I, .CMD_DISCONNECT_NOR_I,
   .CMD_MANUAL_SEND_I, .CMD_FLUSH_BITMAP_CACHE_I, .RD_REQ_I, .FLASH_STATE_O, .CMD_DONE_O,
   .CACHE_FLUSH_O, .RD_READY_O, .RD_VALID_O, .NOR_SCLK_O, .NOR_CS_N_O, .NOR_IO_O, .NOR_IO_OE_O);

// ===== testbench/test_serial_nor_flash_master_states.sv
`timescale 1ns/100ps
module test_serial_nor_flash_master_states;
   localparam logic [31:0] SIG = 32'h3C96_0FF1;
   localparam logic [23:0] ID  = 24'h5C3A17;  // arbitrary id value
   logic        clk     = 1'b0;
   logic        rst     = 1'b1;
   logic [6:0]  cmd     = 7'h00;
   logic [7:0]  tx_byte = 8'h00;
   logic        rd_req  = 1'b0;
   logic [23:0] rd_addr = 24'h000000;
   logic        present = 1'b1;
   logic [31:0] blob    = SIG;
   logic [1:0]  state;
   logic        done, rx_valid, flush, rd_ready, rd_valid, sclk, cs_n;
   logic [7:0]  rx_byte, rd_data, mosi;
   logic [3:0]  io_o, io_oe, mio, pin;
   int          error_cnt = 0;
   int          checks    = 0;
   int          cyc       = 0;
   always #4 clk = ~clk;
   assign pin = (io_oe & io_o) | (~io_oe & mio);
   always @(posedge sclk) mosi <= {mosi[6:0], pin[0]};
   nfm_flash_master #(.BLOB_SIG(SIG)) i_dut (.REF_CLK_I(clk), .RST_I(rst),
      .CMD_GO_FULL_SPEED_I(cmd[0]), .CMD_DISCONNECT_NOR_I(cmd[1]), .CMD_RECONNECT_NOR_I(cmd[2]),
      .CMD_MANUAL_DESELECT_I(cmd[3]), .CMD_MANUAL_SEND_I(cmd[4]), .MAN_TX_BYTE_I(tx_byte),
      .CMD_MANUAL_RECEIVE_I(cmd[5]), .CMD_FLUSH_BITMAP_CACHE_I(cmd[6]), .FLASH_STATE_O(state),
      .CMD_DONE_O(done), .MAN_RX_BYTE_O(rx_byte), .MAN_RX_VALID_O(rx_valid),
      .CACHE_FLUSH_O(flush), .RD_REQ_I(rd_req), .RD_ADDR_I(rd_addr), .RD_READY_O(rd_ready),
      .RD_DATA_O(rd_data), .RD_VALID_O(rd_valid), .NOR_SCLK_O(sclk), .NOR_CS_N_O(cs_n),
      .NOR_IO_O(io_o), .NOR_IO_OE_O(io_oe), .NOR_IO_I(pin));
   nfm_flash_model #(.ID(ID)) i_flash (.sclk_i(sclk), .cs_n_i(cs_n), .io_i(pin),
      .present_i(present), .blob_i(blob), .io_o(mio));
   task automatic tally_and_finish;
      $display("error_cnt %0d checks %0d", error_cnt, checks);
      if (error_cnt == 0 && checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 12000) begin
         error_cnt++;
         tally_and_finish;
      end
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task automatic pulse(input logic [6:0] m);
      @(posedge clk) cmd <= m;
      @(posedge clk) cmd <= 7'h00;
   endtask
   // sel 0 waits for done, 1 for read data
   task automatic wait_hi(input int sel, input int lim);
      int n;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while ((sel ? rd_valid : done) !== 1'b1 && n < lim);
      chk({7'h00, sel ? rd_valid : done}, 8'h01);
   endtask
   task automatic wait_st(input logic [1:0] exp, input int lim);
      repeat (lim) begin
         @(negedge clk);
         if (state === exp) break;
      end
      chk({6'h00, state}, {6'h00, exp});
   endtask
   task automatic do_reset(input logic p);
      @(posedge clk);
      rst <= 1'b1;
      present <= p;
      repeat (20) @(posedge clk);
      rst <= 1'b0;
      @(negedge clk);
      chk({6'h00, state}, 8'h00);
      wait_st(p ? 2'h2 : 2'h1, 500);
   endtask
   task automatic t_refuse;
      int n;
      n = 0;
      pulse(7'h04);
      pulse(7'h10);
      repeat (300) begin
         @(negedge clk);
         if (done !== 1'b0 || state !== 2'h2 || cs_n !== 1'b1) n++;
      end
      chk(n[7:0], 8'h00);
      pulse(7'h40);
      @(negedge clk);
      chk({7'h00, flush}, 8'h01);
   endtask
   task automatic t_fast(input logic [31:0] b, input logic [1:0] exp);
      blob = b;
      pulse(7'h01);
      wait_hi(0, 900);
      repeat (2) @(negedge clk);
      chk({6'h00, state}, {6'h00, exp});
      chk({7'h00, rd_ready}, {7'h00, exp == 2'h3});
   endtask
   task automatic rd_go(input logic [23:0] a);
      int n;
      @(posedge clk);
      rd_req <= 1'b1;
      rd_addr <= a;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (rd_ready !== 1'b1 && n < 200);
      @(posedge clk);
      rd_req <= 1'b0;
   endtask
   task automatic t_reads;
      logic [23:0] a[3] = '{24'h000000, 24'hFFFFFF, 24'h1234A7};
      foreach (a[i]) begin
         rd_go(a[i]);
         wait_hi(1, 200);
         chk(rd_data, a[i][7:0] ^ 8'h5A);
      end
   endtask
   task automatic t_detach;
      int n;
      n = 0;
      rd_go(24'h00ABCD);
      repeat (60) @(posedge clk);
      pulse(7'h02);
      @(negedge clk);
      chk({5'h00, state, done}, 8'h03);
      repeat (120) begin
         @(negedge clk);
         if (rd_valid !== 1'b0) n++;
      end
      chk(n[7:0], 8'h00);
   endtask
   task automatic t_manual;
      tx_byte <= 8'h9F;
      pulse(7'h10);
      wait_hi(0, 120);
      chk(mosi, 8'h9F);
      for (int i = 0; i < 3; i++) begin
         pulse(7'h20);
         wait_hi(0, 120);
         chk({7'h00, rx_valid}, 8'h01);
         chk(rx_byte, ID[23 - 8 * i -: 8]);
      end
      pulse(7'h08);
      repeat (4) @(negedge clk);
      chk({7'h00, cs_n}, 8'h01);
      pulse(7'h04);
      wait_st(2'h2, 500);
      pulse(7'h02);
      @(negedge clk);
      chk({6'h00, state}, 8'h01);
   endtask
   task automatic t_absent;
      logic [7:0] snap;
      do_reset(1'b0);
      snap = {io_o, io_oe};
      repeat (50) @(negedge clk);
      chk({io_o, io_oe}, snap);
      chk({5'h00, cs_n, io_oe[1], sclk}, 8'h04);
   endtask
   initial begin
      do_reset(1'b1);
      t_refuse;
      t_fast(SIG ^ 32'h0000_0001, 2'h2);
      t_fast(SIG, 2'h3);
      t_reads;
      t_detach;
      t_manual;
      t_absent;
      tally_and_finish;
   end
endmodule
